// File: logic/synth_serial_config.sv
// Serial configuration, dividers, lock detect and band select of the core.
`default_nettype none
`include "synth_config_defines.svh"

module synth_serial_config (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Serial link pins
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic load_strobe,
  // Device pins
  input wire logic chipEnable,
  input wire logic reference_input,
  input wire logic feedbackInput,
  // Status and loop controls
  output logic status_output,
  output logic locked,
  output logic refDivPulse,
  output logic fbDivPulse,
  output logic [1:0] antibacklashWidth,
  output logic pump_gain_select,
  output logic [2:0] pumpCurrent,
  output logic pumpThreeState,
  output logic detector_polarity,
  // Oscillator and output stage
  output logic [1:0] coreCurrentCode,
  output logic [1:0] outputLevelCode,
  output logic outputStageOn,
  output logic tuneHold,
  output logic powerDown
);

  localparam int NPINS = 6;
  localparam int LOCK_CYC_RAW = `LOCK_ERROR_NS * `CLOCK_MHZ / 1000;
  localparam int UNLOCK_CYC_RAW = `UNLOCK_ERROR_NS * `CLOCK_MHZ / 1000;
  localparam logic [7:0] LOCK_CYC =
    8'(LOCK_CYC_RAW < 1 ? 1 : LOCK_CYC_RAW);
  localparam logic [7:0] UNLOCK_CYC =
    8'(UNLOCK_CYC_RAW < 1 ? 1 : UNLOCK_CYC_RAW);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [NPINS-1:0] pinRaw;
  logic [NPINS-1:0] pinF;
  logic [NPINS-1:0] pinPrev;
  assign pinRaw = {feedbackInput, reference_input, chipEnable,
                   load_strobe, serialData, serialClock};

  // A pin change counts once the second and third stages agree.
  for (genvar i = 0; i < NPINS; i++) begin : g_sync
    logic s1;
    logic s2;
    logic s3;
    always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
        s1 <= 1'b0;
        s2 <= 1'b0;
        s3 <= 1'b0;
        pinF[i] <= 1'b0;
        pinPrev[i] <= 1'b0;
      end else begin
        s1 <= pinRaw[i];
        s2 <= s1;
        s3 <= s2;
        if (s2 == s3) begin
          pinF[i] <= s3;
        end
        pinPrev[i] <= pinF[i];
      end
    end
  end

  logic sclkRise;
  logic strobeRise;
  logic dataF;
  logic ceF;
  logic refRise;
  logic fbRise;
  assign sclkRise = pinF[0] && !pinPrev[0];
  assign dataF = pinF[1];
  assign strobeRise = pinF[2] && !pinPrev[2];
  assign ceF = pinF[3];
  assign refRise = pinF[4] && !pinPrev[4];
  assign fbRise = pinF[5] && !pinPrev[5];

  // ****************************************
  // Shift register and latches
  // ****************************************
  logic [23:0] shiftReg;
  logic [23:0] control_word_latch;
  logic [23:0] referenceLatch;
  logic [23:0] feedback_divider_latch;
  logic [23:0] testLatch;
  logic fbWrite;
  logic ctlWrite;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      shiftReg <= `LATCH_RESET;
    end else if (sclkRise) begin
      shiftReg <= {shiftReg[22:0], dataF};
    end
  end

  assign ctlWrite = strobeRise && shiftReg[1:0] == `SEL_CONTROL;
  assign fbWrite = strobeRise && shiftReg[1:0] == `SEL_FEEDBACK;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      control_word_latch <= `LATCH_RESET;
      referenceLatch <= `LATCH_RESET;
      feedback_divider_latch <= `LATCH_RESET;
      testLatch <= `LATCH_RESET;
    end else if (strobeRise) begin
      case (shiftReg[1:0])
        `SEL_CONTROL: control_word_latch <= shiftReg;
        `SEL_REFERENCE: referenceLatch <= shiftReg;
        `SEL_FEEDBACK: feedback_divider_latch <= shiftReg;
        default: testLatch <= shiftReg;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pump_gain_select <= 1'b0;
    end else if (ctlWrite) begin
      pump_gain_select <= shiftReg[`CTL_GAIN];
    end else if (fbWrite) begin
      pump_gain_select <= shiftReg[`FB_GAIN];
    end
  end

  // ****************************************
  // Power-down
  // ****************************************
  logic powerdown_mode;
  logic powerdown_request;
  logic divider_reset;
  logic [1:0] syncEdges;
  assign powerdown_mode = control_word_latch[`CTL_PD_MODE];
  assign powerdown_request = control_word_latch[`CTL_PD_REQUEST];
  assign divider_reset = control_word_latch[`CTL_DIV_RESET];

  // The synchronous request waits two reference outputs so the pump is
  // never cut off in the middle of a correction pulse.
  // chip enable power-down
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      powerDown <= 1'b0;
      syncEdges <= 2'h0;
    end else begin
      if (ctlWrite) begin
        syncEdges <= 2'h0;
      end else if (refDivPulse && syncEdges != 2'h2) begin
        syncEdges <= syncEdges + 2'h1;
      end
      powerDown <= !ceF || (powerdown_request &&
                   (!powerdown_mode || syncEdges == 2'h2));
    end
  end

  logic haltCounters;
  assign haltCounters = powerDown || divider_reset;

  // ****************************************
  // Reference and feedback dividers
  // ****************************************
  logic [13:0] refRatio;
  logic [13:0] refCount;
  logic [12:0] fbRatio;
  logic [12:0] fbCount;
  assign refRatio = referenceLatch[`REF_RATIO_HI:`REF_RATIO_LO];
  assign fbRatio = feedback_divider_latch[`FB_RATIO_HI:`FB_RATIO_LO];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      refCount <= 14'h0001;
      refDivPulse <= 1'b0;
    end else if (haltCounters) begin
      refCount <= 14'h0001;
      refDivPulse <= 1'b0;
    end else begin
      refDivPulse <= 1'b0;
      if (refRise) begin
        if (refCount >= refRatio) begin
          refCount <= 14'h0001;
          refDivPulse <= 1'b1;
        end else begin
          refCount <= refCount + 14'h0001;
        end
      end
    end
  end

  // feedback divide, ratio held at least three
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      fbCount <= 13'h0001;
      fbDivPulse <= 1'b0;
    end else if (haltCounters) begin
      fbCount <= 13'h0001;
      fbDivPulse <= 1'b0;
    end else begin
      fbDivPulse <= 1'b0;
      if (fbRise) begin
        if (fbCount >= fbRatio && fbCount >= `FB_RATIO_MIN) begin
          fbCount <= 13'h0001;
          fbDivPulse <= 1'b1;
        end else begin
          fbCount <= fbCount + 13'h0001;
        end
      end
    end
  end

  // ****************************************
  // Phase error and lock detect
  // ****************************************
  logic pendRef;
  logic pendFb;
  logic [7:0] errCount;
  logic [7:0] errCycles;
  logic errDone;
  logic lock_precision;
  logic [2:0] lockNeed;
  logic [2:0] goodRun;
  assign lock_precision = referenceLatch[`REF_PRECISION];

  // A second edge of the same kind before the other one arrives is
  // reported as the largest error, which always counts as out of lock.
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pendRef <= 1'b0;
      pendFb <= 1'b0;
      errCount <= 8'h00;
      errCycles <= 8'h00;
      errDone <= 1'b0;
    end else if (haltCounters) begin
      // Counters held at their load state leave no edge pending, so a stale
      // edge cannot spoil the first detector cycle after a restart.
      pendRef <= 1'b0;
      pendFb <= 1'b0;
      errCount <= 8'h00;
      errDone <= 1'b0;
    end else begin
      errDone <= 1'b0;
      if (errCount != 8'hFF) begin
        errCount <= errCount + 8'h01;
      end
      if (refDivPulse && fbDivPulse) begin
        errDone <= 1'b1;
        errCycles <= (pendRef || pendFb) ? 8'hFF : 8'h00;
        pendRef <= 1'b0;
        pendFb <= 1'b0;
      end else if ((refDivPulse && pendFb) || (fbDivPulse && pendRef)) begin
        errDone <= 1'b1;
        errCycles <= (errCount == 8'hFF) ? 8'hFF : errCount + 8'h01;
        pendRef <= 1'b0;
        pendFb <= 1'b0;
      end else if (refDivPulse || fbDivPulse) begin
        errDone <= pendRef || pendFb;
        errCycles <= 8'hFF;
        pendRef <= refDivPulse;
        pendFb <= fbDivPulse;
        errCount <= 8'h00;
      end
    end
  end

  assign lockNeed = lock_precision ? 3'(`LOCK_CYCLES_HIGH)
                                   : 3'(`LOCK_CYCLES_LOW);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      locked <= 1'b0;
      goodRun <= 3'h0;
    end else if (powerDown) begin
      locked <= 1'b0;
      goodRun <= 3'h0;
    end else if (errDone) begin
      if (errCycles < LOCK_CYC) begin
        if (goodRun != 3'h7) begin
          goodRun <= goodRun + 3'h1;
        end
        if (goodRun + 3'h1 >= lockNeed) begin
          locked <= 1'b1;
        end
      end else begin
        goodRun <= 3'h0;
        if (errCycles > UNLOCK_CYC) begin
          locked <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // Band select
  // ****************************************
  synth_config_pkg::band_state_t bandState;
  logic [2:0] bandDiv;
  logic [2:0] bandMask;
  logic [2:0] bandCount;
  logic bandTick;

  // band clock divide by 1, 2, 4 or 8
  always_comb begin
    case (referenceLatch[`REF_BAND_HI:`REF_BAND_LO])
      2'h0: bandMask = 3'h0;
      2'h1: bandMask = 3'h1;
      2'h2: bandMask = 3'h3;
      default: bandMask = 3'h7;
    endcase
  end
  assign bandTick = refDivPulse && ((bandDiv & bandMask) == bandMask);

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bandDiv <= 3'h0;
    end else if (haltCounters) begin
      bandDiv <= 3'h0;
    end else if (refDivPulse) begin
      bandDiv <= bandDiv + 3'h1;
    end
  end

  // search at power-up and feedback write
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      bandState <= synth_config_pkg::BAND_SEARCH;
      bandCount <= 3'h0;
    end else if (fbWrite) begin
      bandState <= synth_config_pkg::BAND_SEARCH;
      bandCount <= 3'h0;
    end else begin
      case (bandState)
        synth_config_pkg::BAND_SEARCH: begin
          if (bandTick) begin
            bandCount <= bandCount + 3'h1;
            if (bandCount == 3'(`BAND_CYCLES - 1)) begin
              bandState <= synth_config_pkg::BAND_SETTLE;
            end
          end
        end
        synth_config_pkg::BAND_SETTLE: begin
          bandState <= synth_config_pkg::BAND_IDLE;
        end
        default: begin
          bandState <= synth_config_pkg::BAND_IDLE;
        end
      endcase
    end
  end
  assign tuneHold = bandState == synth_config_pkg::BAND_SEARCH;

  // ****************************************
  // Analog codes and status output
  // ****************************************
  logic mute_until_lock;
  assign mute_until_lock = control_word_latch[`CTL_MUTE];

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      antibacklashWidth <= 2'h0;
      pumpCurrent <= 3'h0;
      pumpThreeState <= 1'b1;
      detector_polarity <= 1'b0;
      coreCurrentCode <= 2'h0;
      outputLevelCode <= 2'h0;
      outputStageOn <= 1'b0;
    end else begin
      antibacklashWidth <=
        referenceLatch[`REF_BACKLASH_HI:`REF_BACKLASH_LO];
      pumpCurrent <= pump_gain_select
        ? control_word_latch[`CTL_CUR_TWO_HI:`CTL_CUR_TWO_LO]
        : control_word_latch[`CTL_CUR_ONE_HI:`CTL_CUR_ONE_LO];
      pumpThreeState <= powerDown || control_word_latch[`CTL_PUMP_OFF];
      detector_polarity <= control_word_latch[`CTL_POLARITY];
      coreCurrentCode <= control_word_latch[`CTL_CORE_HI:`CTL_CORE_LO];
      outputLevelCode <= control_word_latch[`CTL_LEVEL_HI:`CTL_LEVEL_LO];
      outputStageOn <= !powerDown && (!mute_until_lock || locked);
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      status_output <= 1'b0;
    end else begin
      case (synth_config_pkg::status_sel_t'(
            control_word_latch[`CTL_STATUS_HI:`CTL_STATUS_LO]))
        synth_config_pkg::STATUS_LOCK: status_output <= locked;
        synth_config_pkg::STATUS_FEEDBACK: status_output <= fbDivPulse;
        synth_config_pkg::STATUS_HIGH: status_output <= 1'b1;
        synth_config_pkg::STATUS_REFERENCE: status_output <= refDivPulse;
        synth_config_pkg::STATUS_BAND: status_output <= tuneHold;
        synth_config_pkg::STATUS_POWER: status_output <= powerDown;
        synth_config_pkg::STATUS_MUTE: status_output <= !outputStageOn;
        default: status_output <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_good_cycle;
    errDone && errCycles < LOCK_CYC;
  endsequence
  sequence s_feedback_load;
    strobeRise && shiftReg[1:0] == `SEL_FEEDBACK;
  endsequence

  a_shift_data_in: assert property (
    sclkRise |=> shiftReg == {$past(shiftReg[22:0]), $past(dataF)})
    else $error("shift register missed a serial bit");
  a_control_load: assert property (
    strobeRise && shiftReg[1:0] == `SEL_CONTROL
    |=> control_word_latch == $past(shiftReg) && $stable(referenceLatch))
    else $error("control word not loaded alone");
  a_feedback_load: assert property (
    s_feedback_load |=> feedback_divider_latch == $past(shiftReg)
    && $stable(control_word_latch))
    else $error("feedback word not loaded alone");
  a_no_stray_load: assert property (
    !strobeRise |=> $stable(control_word_latch)
    && $stable(feedback_divider_latch))
    else $error("latch changed without strobe");
  a_lock_count_met: assert property (
    !locked ##1 locked |-> $past(errDone) && $past(goodRun) + 3'h1 >= lockNeed)
    else $error("lock rose before enough good cycles");
  a_lock_lost_err: assert property (
    errDone && errCycles > UNLOCK_CYC |=> !locked)
    else $error("lock kept after large error");
  a_lock_held: assert property (
    locked && !powerDown && !(errDone && errCycles > UNLOCK_CYC) |=> locked)
    else $error("lock dropped without large error");
  a_band_restart: assert property (
    s_feedback_load |=> tuneHold [*2])
    else $error("band search not started on feedback write");
  a_mute_gate: assert property (
    mute_until_lock && !locked |=> !outputStageOn)
    else $error("output stage on before lock");
  a_chip_disable: assert property (
    !ceF |=> powerDown ##1 pumpThreeState && !locked)
    else $error("chip disable did not power down");
  a_gain_latest: assert property (
    s_feedback_load |=> pump_gain_select == $past(shiftReg[`FB_GAIN]))
    else $error("pump gain not taken from feedback write");

endmodule : synth_serial_config
`default_nettype wire

// File: logic/synth_config_defines.svh
// Bit positions, reset values and timing figures of the synthesizer core.
`ifndef SYNTH_CONFIG_DEFINES_SVH
`define SYNTH_CONFIG_DEFINES_SVH

// ****************************************
// Word layout and latch selection
// ****************************************
`define WORD_BITS 24
`define SEL_CONTROL 2'h0
`define SEL_REFERENCE 2'h1
`define SEL_FEEDBACK 2'h2
`define SEL_TEST 2'h3
`define LATCH_RESET 24'h000000

// ****************************************
// Control latch fields
// ****************************************
`define CTL_PD_MODE 21
`define CTL_PD_REQUEST 20
`define CTL_CUR_TWO_HI 19
`define CTL_CUR_TWO_LO 17
`define CTL_CUR_ONE_HI 16
`define CTL_CUR_ONE_LO 14
`define CTL_LEVEL_HI 13
`define CTL_LEVEL_LO 12
`define CTL_MUTE 11
`define CTL_GAIN 10
`define CTL_PUMP_OFF 9
`define CTL_POLARITY 8
`define CTL_STATUS_HI 7
`define CTL_STATUS_LO 5
`define CTL_DIV_RESET 4
`define CTL_CORE_HI 3
`define CTL_CORE_LO 2

// ****************************************
// Reference and feedback latch fields
// ****************************************
`define REF_BAND_HI 21
`define REF_BAND_LO 20
`define REF_PRECISION 18
`define REF_BACKLASH_HI 17
`define REF_BACKLASH_LO 16
`define REF_RATIO_HI 15
`define REF_RATIO_LO 2
`define FB_GAIN 21
`define FB_RATIO_HI 20
`define FB_RATIO_LO 8
`define FB_RATIO_MIN 13'h0003

// ****************************************
// Timing and counts
// ****************************************
`define CLOCK_MHZ 40
`define LOCK_ERROR_NS 15
`define UNLOCK_ERROR_NS 25
`define LOCK_CYCLES_LOW 3
`define LOCK_CYCLES_HIGH 5
`define BAND_CYCLES 5
`define SYNC_STAGES 3

`endif

// File: logic/synth_config_pkg.sv
// Types shared by the synthesizer digital core.
`default_nettype none
package synth_config_pkg;
  typedef enum logic [2:0] {
    BAND_IDLE = 3'h1,
    BAND_SEARCH = 3'h2,
    BAND_SETTLE = 3'h4
  } band_state_t;
  typedef enum logic [2:0] {
    STATUS_LOW = 3'h0,
    STATUS_LOCK = 3'h1,
    STATUS_FEEDBACK = 3'h2,
    STATUS_HIGH = 3'h3,
    STATUS_REFERENCE = 3'h4,
    STATUS_BAND = 3'h5,
    STATUS_POWER = 3'h6,
    STATUS_MUTE = 3'h7
  } status_sel_t;
endpackage : synth_config_pkg
`default_nettype wire

// File: test/serial_host_model.sv
// Host model that writes words over the three-wire serial link.
`default_nettype none
module serial_host_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Serial link pins
  output logic serialClock,
  output logic serialData,
  output logic load_strobe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    serialClock = 1'b0;
    serialData = 1'b0;
    load_strobe = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : tick

  // ****************************************
  // Word transfer
  // ****************************************
  // last bits select, never code 3.
  task automatic send(input logic [25:0] word, input int nBits);
    wait (reset_n === 1'b1);
    for (int i = nBits - 1; i >= 0; i--) begin
      tick(1);
      serialData = word[i];
      tick(4);
      serialClock = 1'b1;
      tick(4);
      serialClock = 1'b0;
    end
    tick(4);
    // Stale data is flipped so nothing can lean on its last level.
    serialData = ~serialData;
    load_strobe = 1'b1;
    tick(4);
    load_strobe = 1'b0;
  endtask : send
endmodule : serial_host_model
`default_nettype wire

// File: test/synth_serial_config_tb.sv
// Self-checking bench for the synthesizer serial configuration core.
`default_nettype none
module synth_serial_config_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock, reset_n, chipEnable, refWave, fbRun;
  logic status_output, locked, refDivPulse, fbDivPulse, pump_gain_select;
  logic pumpThreeState, detector_polarity, outputStageOn, tuneHold;
  logic powerDown;
  logic [1:0] antibacklashWidth, coreCurrentCode, outputLevelCode;
  logic [2:0] pumpCurrent;
  wire serialClock, serialData, load_strobe;
  wire reference_input = refWave;
  wire feedbackInput = refWave & fbRun;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;

  synth_serial_config dut_u (.clock, .reset_n, .serialClock, .serialData,
    .load_strobe, .chipEnable, .reference_input, .feedbackInput,
    .status_output, .locked, .refDivPulse, .fbDivPulse, .antibacklashWidth,
    .pump_gain_select, .pumpCurrent, .pumpThreeState, .detector_polarity,
    .coreCurrentCode, .outputLevelCode, .outputStageOn, .tuneHold,
    .powerDown);
  serial_host_model host_u (.clock, .reset_n, .serialClock, .serialData,
    .load_strobe);

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Reference toggles every four cycles; feedback copies it when running.
  initial begin
    refWave = 1'b0;
    forever begin
      repeat (4) @(posedge clock);
      #2;
      refWave = ~refWave;
    end
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      errors++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [23:0] seen,
    input logic [23:0] expected);
    n_checks++;
    if (seen !== expected) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, expected, seen);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #2;
  endtask : cyc

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    check("reset outs", {locked, status_output, refDivPulse, fbDivPulse,
      outputStageOn, powerDown, tuneHold, pumpThreeState}, 8'h03);
    $display("reset test done");
  endtask : test_reset

  task automatic test_config();
    host_u.send({2'h3, 24'h12000D}, 26);
    host_u.send(26'h0AA574, 24);
    cyc(8);
    check("backlash", antibacklashWidth, 2'h2);
    check("core", coreCurrentCode, 2'h1);
    check("level", outputLevelCode, 2'h2);
    check("polarity", detector_polarity, 1'b1);
    check("status high", status_output, 1'b1);
    check("gain ctl", pump_gain_select, 1'b1);
    check("current two", pumpCurrent, 3'h5);
    check("pump on", pumpThreeState, 1'b0);
    check("power", powerDown, 1'b0);
    host_u.send(26'h000302, 24);
    cyc(8);
    check("gain fb", pump_gain_select, 1'b0);
    check("current one", pumpCurrent, 3'h2);
    check("band hold", tuneHold, 1'b1);
    // A power-down clears any lock picked up before the counters were held.
    chipEnable = 1'b0;
    cyc(8);
    chipEnable = 1'b1;
    cyc(8);
    $display("config test done");
  endtask : test_config

  task automatic run_lock(input int wantLock, input int wantBand);
    int pulses, bandAt, lockAt, last, period, skew, leak;
    pulses = 0;
    bandAt = -1;
    lockAt = -1;
    last = 0;
    period = 0;
    skew = 0;
    leak = 0;
    host_u.send(26'h0AAD24, 24);
    // Let the new mute setting reach the output stage before watching it.
    cyc(2);
    for (int i = 0; i < 2000 && (lockAt < 0 || bandAt < 0); i++) begin
      cyc(1);
      if (refDivPulse === 1'b1) begin
        pulses++;
        period = i - last;
        last = i;
      end
      skew += (fbDivPulse !== refDivPulse);
      leak += (outputStageOn === 1'b1 && lockAt < 0);
      if (tuneHold === 1'b0 && bandAt < 0) bandAt = pulses;
      if (locked === 1'b1 && lockAt < 0) lockAt = pulses;
    end
    check("lock pulses", lockAt, wantLock);
    if (wantBand > 0) check("band pulses", bandAt, wantBand);
    check("ref period", period, 24);
    check("fb skew", skew, 0);
    check("early output", leak, 0);
    cyc(2);
    check("output on", outputStageOn, 1'b1);
    check("status lock", status_output, 1'b1);
    $display("lock test done");
  endtask : run_lock

  task automatic test_unlock();
    fbRun = 1'b0;
    for (int i = 0; i < 300 && locked === 1'b1; i++) cyc(1);
    cyc(2);
    check("unlock", locked, 1'b0);
    check("muted", outputStageOn, 1'b0);
    check("gain latest", pump_gain_select, 1'b1);
    host_u.send(26'h0AAD34, 24);
    host_u.send(26'h16000D, 24);
    fbRun = 1'b1;
    run_lock(5, -1);
  endtask : test_unlock

  task automatic test_powerdown();
    chipEnable = 1'b0;
    cyc(10);
    check("pd", {powerDown, pumpThreeState, outputStageOn}, 3'h6);
    chipEnable = 1'b1;
    cyc(10);
    check("pd off", powerDown, 1'b0);
    // Software power-down: immediate, then gated by two reference pulses.
    host_u.send(26'h1AADC4, 24);
    cyc(8);
    check("soft pd", {powerDown, status_output}, 2'h3);
    host_u.send(26'h0AADC4, 24);
    cyc(8);
    check("soft pd off", {powerDown, status_output}, 2'h0);
    host_u.send(26'h3AADC4, 24);
    cyc(8);
    check("sync pd wait", powerDown, 1'b0);
    cyc(60);
    check("sync pd", {powerDown, pumpThreeState}, 2'h3);
    $display("power-down test done");
  endtask : test_powerdown

  initial begin
    reset_n = 1'b0;
    chipEnable = 1'b1;
    fbRun = 1'b1;
    cyc(2);
    test_reset();
    cyc(1);
    reset_n = 1'b1;
    test_config();
    run_lock(3, 10);
    test_unlock();
    test_powerdown();
    wrap_up();
  end
endmodule : synth_serial_config_tb
`default_nettype wire
